//--- src/pll_base_clock_selector.v
// Purpose: Base clock selection, PLL interlocks and setting registers
// Assumes: osc_clock, vco_clock and lock_detect are synchronous samples
// Notes:   Registers over AXI4-Lite; one clock domain, clk_sys
//
// Contract
// - Divider or multiplier value zero acts as value one.
// - Range zero disables PLL, blocks VCO selection, forces oscillator.
// - Source change waits three oscillator edges and, while PLL is enabled, three VCO edges, output held.
// - Transition output is divided by two for duty correction, except on the direct oscillator path.
// - Base clock select bit chooses which source drives the output.
// - VCO cannot be selected while PLL power is off.
// - PLL cannot be turned off while VCO is selected.
// - Power and VCO selection never both change in one write.
// - Prescaler, power range, multiplier, range, divider writable only when off.
// - Centre frequency equals L times two to E times 38.4 kHz.
// - Output is oscillator, half oscillator or half VCO, 50 percent duty.
// - Interrupt output is the OR of masked sticky lock-change and switch-done events.
// - PLL reference clock is a buffered copy of the oscillator.
// - Writing zero range disables PLL and clears base clock select.
// - Reset sets PLL power on so the loop settles.
// - Reset loads the multiplier with 64.
`timescale 1ns/100ps
`include "clock_selector_consts.vh"

module pll_base_clock_selector (
    input wire clk_sys,
    input wire srst,
    input wire osc_clock,
    input wire vco_clock,
    input wire lock_detect,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg base_clock_out,
    output reg pll_ref_clock,
    output reg pll_enable,
    output reg [1:0] prescale_power,
    output reg [1:0] vco_power_range_field,
    output reg [11:0] feedback_multiplier,
    output reg [7:0] ref_divider,
    output reg [7:0] vco_range,
    output reg [31:0] centre_range_freq,
    output reg clockgen_irq
);

    localparam ST_RUN = 1'b0;
    localparam ST_WAIT = 1'b1;

    // ************************************************************
    // Helpers
    // ************************************************************

    // Zero maps to one for modulo dividers
    function [11:0] zero_as_one;
        input [11:0] v;
        begin
            zero_as_one = (v == 12'h000) ? 12'h001 : v;
        end
    endfunction

    // Address match on an aligned word
    function addr_is;
        input [4:0] a;
        input [4:0] ofs;
        begin
            addr_is = (a[4:2] == ofs[4:2]);
        end
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    reg pll_power_on;
    reg base_clock_select;
    reg osc_direct;
    reg [1:0] prescale_reg;
    reg [1:0] vpr_reg;
    reg [7:0] multiplier_low_reg;
    reg [3:0] multiplier_high_reg;
    reg [7:0] vco_range_reg;
    reg [7:0] ref_divider_reg;
    reg [`EVT_WIDTH-1:0] event_status;
    reg [`EVT_WIDTH-1:0] event_mask;
    reg aw_hold;
    reg [4:0] aw_addr;
    reg w_hold;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg vco_q;
    reg lock_q;
    reg sw_state;
    reg [1:0] active_src;
    reg [1:0] osc_cnt;
    reg [1:0] vco_cnt;
    reg switch_done;

    wire range_zero = (vco_range_reg == 8'h00);
    wire osc_rise = osc_clock & ~pll_ref_clock;
    wire vco_rise = vco_clock & ~vco_q;
    wire wr_fire = aw_hold & w_hold & ~s_axi_bvalid;
    wire wr_lane = w_strb[0];
    wire lock_event = lock_detect ^ lock_q;
    wire [11:0] div_eff = zero_as_one({4'h0, ref_divider_reg});

    // Source the selector aims at; range zero forces oscillator
    wire vco_wanted = base_clock_select & ~range_zero;
    wire [1:0] target_src = vco_wanted ? `SRC_VCO_HALF :
        (osc_direct ? `SRC_OSC_FULL : `SRC_OSC_HALF);

    // Proposed control bits from the write data
    wire new_on = w_data[`CTL_ON_BIT];
    wire new_bcs = w_data[`CTL_BCS_BIT];
    wire on_change = (new_on != pll_power_on);
    wire bcs_change = (new_bcs != base_clock_select);
    wire both_change = on_change & bcs_change;

    // ************************************************************
    // Write address and data capture
    // ************************************************************

    // Address and data in either order, answered after both
    always @(posedge clk_sys) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 5'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr <= `OFS_MASK && aw_addr[1:0] == 2'h0) begin
                    s_axi_bresp <= `RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Control and setting registers
    // ************************************************************

    // Interlocked control bits; settings frozen while running
    always @(posedge clk_sys) begin
        if (srst) begin
            pll_power_on <= 1'b1;
            base_clock_select <= 1'b0;
            osc_direct <= 1'b0;
            prescale_reg <= 2'h0;
            vpr_reg <= 2'h0;
            multiplier_low_reg <= `RST_MULT;
            multiplier_high_reg <= 4'h0;
            vco_range_reg <= `RST_RANGE;
            ref_divider_reg <= `RST_DIVIDER;
            event_mask <= {`EVT_WIDTH{1'b0}};
        end else if (wr_fire & wr_lane) begin
            if (addr_is(aw_addr, `OFS_CONTROL)) begin
                osc_direct <= w_data[`CTL_DIRECT_BIT];
                if (!pll_power_on) begin
                    prescale_reg <= w_data[`CTL_PRE_LSB+1:`CTL_PRE_LSB];
                    vpr_reg <= w_data[`CTL_VPR_LSB+1:`CTL_VPR_LSB];
                end
                // A write that flips both bits changes neither
                if (!both_change) begin
                    if (new_on | ~base_clock_select) begin
                        pll_power_on <= new_on & ~range_zero;
                    end
                    if (~new_bcs | (pll_power_on & ~range_zero)) begin
                        base_clock_select <= new_bcs;
                    end
                end
            end
            if (!pll_power_on) begin
                if (addr_is(aw_addr, `OFS_MULT_LOW)) begin
                    multiplier_low_reg <= w_data[7:0];
                end
                if (addr_is(aw_addr, `OFS_MULT_HIGH)) begin
                    multiplier_high_reg <= w_data[3:0];
                end
                if (addr_is(aw_addr, `OFS_VCO_RANGE)) begin
                    vco_range_reg <= w_data[7:0];
                    if (w_data[7:0] == 8'h00) begin
                        pll_power_on <= 1'b0;
                        base_clock_select <= 1'b0;
                    end
                end
                if (addr_is(aw_addr, `OFS_REF_DIVIDER)) begin
                    ref_divider_reg <= w_data[7:0];
                end
            end
            if (addr_is(aw_addr, `OFS_MASK)) begin
                event_mask <= w_data[`EVT_WIDTH-1:0];
            end
        end
    end

    // ************************************************************
    // Event status and interrupt
    // ************************************************************

    // Sticky events, write one to clear; set wins over clear
    always @(posedge clk_sys) begin
        if (srst) begin
            event_status <= {`EVT_WIDTH{1'b0}};
            lock_q <= 1'b0;
            clockgen_irq <= 1'b0;
        end else begin
            lock_q <= lock_detect;
            event_status <= (event_status &
                ~((wr_fire & wr_lane & addr_is(aw_addr, `OFS_STATUS)) ?
                w_data[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}})) |
                {switch_done, lock_event};
            clockgen_irq <= |(event_status & event_mask);
        end
    end

    // ************************************************************
    // Register read
    // ************************************************************

    // One read at a time, answered a cycle after the address
    always @(posedge clk_sys) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                if (s_axi_araddr[1:0] != 2'h0) begin
                    s_axi_rresp <= `RESP_SLVERR;
                end else if (addr_is(s_axi_araddr, `OFS_CONTROL)) begin
                    s_axi_rdata[6:0] <= {osc_direct, pll_power_on,
                        base_clock_select, vpr_reg, prescale_reg};
                end else if (addr_is(s_axi_araddr, `OFS_MULT_LOW)) begin
                    s_axi_rdata[7:0] <= multiplier_low_reg;
                end else if (addr_is(s_axi_araddr, `OFS_MULT_HIGH)) begin
                    s_axi_rdata[3:0] <= multiplier_high_reg;
                end else if (addr_is(s_axi_araddr, `OFS_VCO_RANGE)) begin
                    s_axi_rdata[7:0] <= vco_range_reg;
                end else if (addr_is(s_axi_araddr, `OFS_REF_DIVIDER)) begin
                    s_axi_rdata[7:0] <= ref_divider_reg;
                end else if (addr_is(s_axi_araddr, `OFS_STATUS)) begin
                    s_axi_rdata[`EVT_WIDTH-1:0] <= event_status;
                    s_axi_rdata[`ST_LOCK_BIT] <= lock_detect;
                    s_axi_rdata[`ST_SRC_LSB+1:`ST_SRC_LSB] <= active_src;
                    s_axi_rdata[`ST_BUSY_BIT] <= sw_state;
                end else if (addr_is(s_axi_araddr, `OFS_MASK)) begin
                    s_axi_rdata[`EVT_WIDTH-1:0] <= event_mask;
                end else begin
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Settings driven to the analog loop
    // ************************************************************

    // Effective loop settings with zero multiplier or divider treated as one
    always @(posedge clk_sys) begin
        if (srst) begin
            pll_enable <= 1'b0;
            prescale_power <= 2'h0;
            vco_power_range_field <= 2'h0;
            feedback_multiplier <= 12'h001;
            ref_divider <= 8'h01;
            vco_range <= 8'h00;
            centre_range_freq <= 32'h00000000;
        end else begin
            pll_enable <= pll_power_on & ~range_zero;
            prescale_power <= prescale_reg;
            vco_power_range_field <= vpr_reg;
            feedback_multiplier <= zero_as_one({multiplier_high_reg,
                multiplier_low_reg});
            ref_divider <= div_eff[7:0];
            vco_range <= vco_range_reg;
            centre_range_freq <= ({24'h000000, vco_range_reg} << vpr_reg) *
                `NOM_STEP_HZ;
        end
    end

    // ************************************************************
    // Base clock transition and divider
    // ************************************************************

    // Holds output still until three oscillator edges, and three VCO edges while pll_enable is set, have passed
    always @(posedge clk_sys) begin
        if (srst) begin
            pll_ref_clock <= 1'b0;
            vco_q <= 1'b0;
            sw_state <= ST_RUN;
            active_src <= `SRC_OSC_HALF;
            osc_cnt <= 2'h0;
            vco_cnt <= 2'h0;
            switch_done <= 1'b0;
            base_clock_out <= 1'b0;
        end else begin
            pll_ref_clock <= osc_clock;
            vco_q <= vco_clock;
            switch_done <= 1'b0;
            case (sw_state)
                ST_RUN: begin
                    if (target_src != active_src) begin
                        sw_state <= ST_WAIT;
                        osc_cnt <= 2'h0;
                        vco_cnt <= 2'h0;
                    end else if (active_src == `SRC_OSC_FULL) begin
                        base_clock_out <= osc_clock;
                    end else if (active_src == `SRC_VCO_HALF) begin
                        if (vco_rise) begin
                            base_clock_out <= ~base_clock_out;
                        end
                    end else if (osc_rise) begin
                        base_clock_out <= ~base_clock_out;
                    end
                end
                ST_WAIT: begin
                    // Output keeps its level; a dead VCO stalls this only while pll_enable is set
                    if (osc_rise && osc_cnt != `SWITCH_EDGES) begin
                        osc_cnt <= osc_cnt + 2'h1;
                    end
                    if (vco_rise && vco_cnt != `SWITCH_EDGES) begin
                        vco_cnt <= vco_cnt + 2'h1;
                    end
                    if (osc_cnt == `SWITCH_EDGES &&
                        (vco_cnt == `SWITCH_EDGES || !pll_enable)) begin
                        sw_state <= ST_RUN;
                        active_src <= target_src;
                        switch_done <= 1'b1;
                    end
                end
                default: begin
                    sw_state <= ST_RUN;
                end
            endcase
        end
    end

endmodule

//--- common/clock_selector_consts.vh
// Purpose: Offsets, fields, reset values and counts of the clock selector
// Assumes: Included by its bare name from the design file
// Notes:   Definitions only
`ifndef CLOCK_SELECTOR_CONSTS_VH
`define CLOCK_SELECTOR_CONSTS_VH

// ************************************************************
// Register byte addresses
// ************************************************************
`define OFS_CONTROL 5'h00
`define OFS_MULT_LOW 5'h04
`define OFS_MULT_HIGH 5'h08
`define OFS_VCO_RANGE 5'h0c
`define OFS_REF_DIVIDER 5'h10
`define OFS_STATUS 5'h14
`define OFS_MASK 5'h18

// ************************************************************
// Control register fields
// ************************************************************
`define CTL_PRE_LSB 0
`define CTL_VPR_LSB 2
`define CTL_BCS_BIT 4
`define CTL_ON_BIT 5
`define CTL_DIRECT_BIT 6

// ************************************************************
// Status register fields
// ************************************************************
`define ST_LOCK_EVT_BIT 0
`define ST_SWITCH_EVT_BIT 1
`define ST_LOCK_BIT 8
`define ST_SRC_LSB 9
`define ST_BUSY_BIT 11
`define EVT_WIDTH 2

// ************************************************************
// Reset values
// ************************************************************
`define RST_MULT 8'h40
`define RST_RANGE 8'h40
`define RST_DIVIDER 8'h01

// ************************************************************
// Timing and arithmetic
// ************************************************************
`define SWITCH_EDGES 2'h3
`define NOM_STEP_HZ 32'h00009600
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ************************************************************
// Base clock sources
// ************************************************************
`define SRC_OSC_HALF 2'h0
`define SRC_VCO_HALF 2'h1
`define SRC_OSC_FULL 2'h2

`endif

//--- tb/pll_base_clock_selector_asserts.sv
// Purpose: Port-level assertions for the base clock selector
// Assumes: One clock domain, clk_sys, synchronous reset srst
// Notes:   Bound to the design top after the checker module
`timescale 1ns/100ps
`include "clock_selector_consts.vh"

module clk_sel_checker (
    input wire clk_sys,
    input wire srst,
    input wire osc_clock,
    input wire pll_ref_clock,
    input wire pll_enable,
    input wire base_clock_out,
    input wire [1:0] prescale_power,
    input wire [1:0] vco_power_range_field,
    input wire [11:0] feedback_multiplier,
    input wire [7:0] ref_divider,
    input wire [7:0] vco_range,
    input wire [31:0] centre_range_freq,
    input wire clockgen_irq,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire s_axi_bvalid,
    input wire s_axi_bready
);
    reg up;
    reg [4:0] osc_h;
    wire osc_flat;

    // ************
    // Helper logic
    // ************
    // Clean previous cycle; recent oscillator samples
    always @(posedge clk_sys) begin
        up <= !srst;
        osc_h <= {osc_h[3:0], osc_clock};
    end
    assign osc_flat = (osc_h == 5'h00) || (osc_h == 5'h1f);

    // **********
    // Properties
    // **********
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    ref_copy_a: assert property (up |-> pll_ref_clock == $past(osc_clock))
        else $error("ref clock mismatch");
    mult_nonzero_a: assert property (feedback_multiplier != 12'h000)
        else $error("multiplier zero");
    div_nonzero_a: assert property (ref_divider != 8'h00)
        else $error("divider zero");
    range_off_a: assert property (up && vco_range == 8'h00 |-> !pll_enable)
        else $error("PLL on at range zero");
    settings_lock_a: assert property (up && pll_enable && $past(pll_enable)
        |-> $stable({prescale_power, vco_power_range_field,
        feedback_multiplier, ref_divider, vco_range}))
        else $error("settings moved while on");
    off_blocks_a: assert property (up && !pll_enable && osc_flat
        |-> $stable(base_clock_out)) else $error("base moved without osc");
    centre_freq_a: assert property (up |-> centre_range_freq ==
        ({24'h0, vco_range} << vco_power_range_field) * `NOM_STEP_HZ)
        else $error("centre wrong");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> ##[0:1] s_axi_rvalid) else $error("read not answered");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("rvalid held");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("bvalid held");

    cover property ($rose(clockgen_irq));
    cover property ($fell(pll_enable));
    cover property (up && $changed(base_clock_out));
endmodule

bind pll_base_clock_selector clk_sel_checker u_chk (.clk_sys, .srst,
    .osc_clock, .pll_ref_clock, .pll_enable, .base_clock_out,
    .prescale_power, .vco_power_range_field, .feedback_multiplier,
    .ref_divider, .vco_range, .centre_range_freq, .clockgen_irq,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bvalid, .s_axi_bready);

//--- tb/clock_source_model.sv
// Purpose: Source clocks and base clock consumer beside the selector
// Assumes: Clocks are level samples stepped on clk_sys
// Notes:   VCO runs free so a wrong pick shows on the base clock
`timescale 1ns/100ps

module clock_source_model #(
    parameter int OSC_HALF = 6,
    parameter int VCO_HALF = 2
) (
    input wire clk_sys,
    input wire srst,
    input wire clr_stats,
    input wire base_clock_out,
    output logic osc_clock,
    output logic vco_clock,
    output int period,
    output int min_width
);
    int osc_cnt = 0, vco_cnt = 0, since_rise = 0, width = 0;
    logic base_prev = 1'b0;

    // Square waves from the oscillator and the VCO
    always @(posedge clk_sys) begin
        osc_cnt <= (osc_cnt + 1) % OSC_HALF;
        vco_cnt <= (vco_cnt + 1) % VCO_HALF;
        if (srst) begin
            osc_clock <= 1'b0;
            vco_clock <= 1'b0;
        end else begin
            if (osc_cnt == 0) osc_clock <= !osc_clock;
            if (vco_cnt == 0) vco_clock <= !vco_clock;
        end
    end

    // Period between rises and shortest level of the base clock
    always @(posedge clk_sys) begin
        base_prev <= base_clock_out;
        since_rise <= since_rise + 1;
        width <= width + 1;
        if (clr_stats || srst) min_width <= 1000;
        if (base_clock_out != base_prev) begin
            width <= 1;
            if (width < min_width && !clr_stats) min_width <= width;
            if (base_clock_out) begin
                period <= since_rise;
                since_rise <= 1;
            end
        end
    end
endmodule

//--- tb/pll_base_clock_selector_tb.sv
// Purpose: Register-level test of the base clock selector
// Assumes: Source model drives osc and vco clocks
// Notes:   Bus tasks hold each channel until its handshake
`timescale 1ns/100ps
`include "clock_selector_consts.vh"

module pll_base_clock_selector_tb;
    logic clk_sys = 0, srst = 1, lock_detect = 0, clr_stats = 0;
    logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, st;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0] rsp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, osc_clock, vco_clock, base_clock_out;
    wire pll_ref_clock, pll_enable, clockgen_irq;
    wire [1:0] s_axi_bresp, s_axi_rresp, prescale_power;
    wire [1:0] vco_power_range_field;
    wire [31:0] s_axi_rdata, centre_range_freq;
    wire [11:0] feedback_multiplier;
    wire [7:0] ref_divider, vco_range;
    int period, min_width, n;
    int errors = 0, cmp_count = 0;
    logic [4:0] ra [5] = '{`OFS_MULT_LOW, `OFS_MULT_HIGH, `OFS_VCO_RANGE,
        `OFS_REF_DIVIDER, `OFS_MASK};
    logic [31:0] rv [5] = '{'h40, 0, 'h40, 1, 0};

    pll_base_clock_selector u_dut (.clk_sys, .srst, .osc_clock, .vco_clock,
        .lock_detect, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .base_clock_out, .pll_ref_clock,
        .pll_enable, .prescale_power, .vco_power_range_field,
        .feedback_multiplier, .ref_divider, .vco_range, .centre_range_freq,
        .clockgen_irq);
    clock_source_model u_src (.clk_sys, .srst, .clr_stats, .base_clock_out,
        .osc_clock, .vco_clock, .period, .min_width);

    // ***********
    // Bench tasks
    // ***********
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic hang(input string what);
        errors++;
        $display("[FAIL] %s expected done seen timeout", what);
        test_done();
    endtask

    // Write, address and data offered together
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic aw = 1, w = 1, b = 1;
        int k = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (b) begin
            @(posedge clk_sys);
            if (++k > 50) hang("write");
            if (s_axi_bvalid) begin
                b = 0;
                rsp = s_axi_bresp;
                s_axi_bready <= 0;
            end
            if (aw && s_axi_awready) begin
                aw = 0;
                s_axi_awvalid <= 0;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 0;
            end
        end
    endtask

    // Read one word into st, response into rsp
    task automatic rd(input logic [4:0] a);
        logic ar = 1;
        int k = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(posedge clk_sys);
            if (++k > 50) hang("read");
            if (!ar && s_axi_rvalid) break;
            if (ar && s_axi_arready) begin
                ar = 0;
                s_axi_arvalid <= 0;
            end
        end
        st = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    // Poll until the source is active and idle
    task automatic wait_src(input logic [1:0] src);
        int k = 0;
        do begin
            rd(`OFS_STATUS);
            if (++k > 40) hang("switch");
        end while (st[11:9] !== {1'b0, src});
        repeat (60) @(posedge clk_sys);
    endtask

    task automatic ctl_chk(input logic [31:0] d, input logic [31:0] e);
        wr(`OFS_CONTROL, d);
        rd(`OFS_CONTROL);
        chk("control", e, st);
    endtask

    // *************
    // Main sequence
    // *************
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 0;
        rd(`OFS_CONTROL);
        chk("control reset", 32'h20, st);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i]);
            chk("reset value", rv[i], st);
        end
        wr(`OFS_MULT_LOW, 32'h55);
        rd(`OFS_MULT_LOW);
        chk("locked multiplier", 32'h40, st);
        ctl_chk(32'h10, 32'h20);
        clr_stats <= 1;
        @(posedge clk_sys);
        clr_stats <= 0;
        ctl_chk(32'h30, 32'h30);
        wait_src(2'h1);
        chk("vco half period", 8, period);
        ctl_chk(32'h10, 32'h30);
        ctl_chk(32'h00, 32'h30);
        ctl_chk(32'h20, 32'h20);
        wait_src(2'h0);
        chk("osc half period", 24, period);
        chk("no partial pulse", 1, min_width >= 4);
        ctl_chk(32'h00, 32'h00);
        ctl_chk(32'h10, 32'h00);
        wr(`OFS_MULT_LOW, 32'h0);
        wr(`OFS_MULT_HIGH, 32'h0);
        wr(`OFS_REF_DIVIDER, 32'h0);
        wr(`OFS_CONTROL, 32'h09);
        wr(`OFS_VCO_RANGE, 32'h80);
        repeat (4) @(posedge clk_sys);
        chk("multiplier", 32'h1, feedback_multiplier);
        chk("divider", 32'h1, ref_divider);
        chk("P and E", 32'h6, {prescale_power, vco_power_range_field});
        chk("centre", 32'h012c0000, centre_range_freq);
        wr(`OFS_VCO_RANGE, 32'h0);
        ctl_chk(32'h29, 32'h09);
        chk("pll enable", 0, pll_enable);
        wr(`OFS_VCO_RANGE, 32'h40);
        ctl_chk(32'h29, 32'h29);
        ctl_chk(32'h69, 32'h69);
        wait_src(2'h2);
        chk("direct period", 12, period);
        wr(`OFS_STATUS, 32'h3);
        wr(`OFS_MASK, 32'h1);
        lock_detect <= 1;
        for (n = 0; n < 20 && clockgen_irq !== 1'b1; n++) @(posedge clk_sys);
        chk("irq raised", 1, clockgen_irq);
        rd(`OFS_STATUS);
        chk("lock status", 32'h101, st & 32'h101);
        wr(`OFS_STATUS, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk("irq cleared", 0, clockgen_irq);
        wr(`OFS_MASK, 32'h0);
        lock_detect <= 0;
        repeat (10) @(posedge clk_sys);
        chk("irq masked", 0, clockgen_irq);
        rd(`OFS_STATUS);
        chk("masked event", 32'h1, st & 32'h101);
        wr(5'h1c, 32'h1);
        chk("unmapped write", `RESP_SLVERR, rsp);
        rd(5'h1c);
        chk("unmapped read", `RESP_SLVERR, rsp);
        test_done();
    end
endmodule
